// file: bsd_params.svh
// Purpose: Address map and field constants for bus select and memory decode
// Assumes: 16-bit processor address, 8-bit data
// Notes:   Shared by the decoder and the slot select latch
`ifndef BSD_PARAMS_SVH
`define BSD_PARAMS_SVH
`define BSD_ONCHIP_LAST   16'h007f
`define BSD_RAM_BASE      16'h2000
`define BSD_RAM_LAST      16'h27ff
`define BSD_EXP_BASE      16'h2800
`define BSD_EXP_LAST      16'h2fff
`define BSD_LATCH_ADDR    16'h3000
`define BSD_TP_BASE       16'h3800
`define BSD_TP_LAST       16'h3fff
`define BSD_BLK_MSB       15
`define BSD_BLK_LSB       13
`define BSD_BLK_LOW       3'h0
`define BSD_BLK_RAMIO     3'h1
`define BSD_BLK_ROM       3'h7
`define BSD_ROM_PICK_BIT  12
`define BSD_LATCH_RESET   8'h00
`endif

// file: bsd_pkg.sv
// Purpose: Types for bus select and memory decode
// Assumes: Nothing beyond the constants header
// Notes:   Data path owner of the current cycle
package bsd_pkg;
    typedef enum logic [2:0] {BSD_NONE, BSD_INT, BSD_EXT, BSD_SWITCH, BSD_ONCHIP} bsd_src_t;
endpackage

// file: bsd_slot_latch.sv
// Purpose: Write-only slot select latch
// Assumes: Load strobe already decoded and aligned to the clock fall
// Notes:   No read path exists, so software must shadow the value
`timescale 1ns/1ns
`include "bsd_params.svh"
module bsd_slot_latch
    import bsd_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              load_in,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] q_out
);
    logic [DATA_W-1:0] q_r;
    logic [DATA_W-1:0] q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        if (load_in)
            q_nxt = data_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            q_r <= DATA_W'(`BSD_LATCH_RESET);
        else
            q_r <= q_nxt;
    end

    assign q_out = q_r;

    chk_latch_holds: assert property (@(posedge clk_in) disable iff (srst_in)
        !load_in |=> $stable(q_r))
        else $error("slot latch changed without a load");
    chk_latch_loads: assert property (@(posedge clk_in) disable iff (srst_in)
        load_in |=> q_r == $past(data_in))
        else $error("slot latch missed its load data");
endmodule

// file: bsd_decode.sv
// Purpose: Data bus selection, memory selects and slot latch control
// Assumes: All processor pins asynchronous to REF_CLK_IN, two-flop synced
// Notes:   Outputs lag the pins by three clocks; phi2 must be slow vs 25 MHz
`timescale 1ns/1ns
`include "bsd_params.svh"
module bsd_decode
    import bsd_pkg::*;
#(
    parameter int   ADDR_W          = 16,
    parameter int   DATA_W          = 8,
    parameter int   SLOTS           = 6,
    parameter bit   EXP_RAM_PRESENT = 1'b0
)
(
    input  wire logic              REF_CLK_IN,
    input  wire logic              SRST_IN,
    input  wire logic [ADDR_W-1:0] ADDR_IN,
    input  wire logic [DATA_W-1:0] DATA_IN,
    input  wire logic              VALID_ADDR_STROBE_IN,
    input  wire logic              READ_NOT_WRITE_IN,
    input  wire logic              PHASE_TWO_CLOCK_IN,
    input  wire logic              FORCED_INSTR_IN,
    input  wire logic              EXT_INHIBIT_IN,
    input  wire logic              ROM_DISABLE_IN,
    output logic                   INT_BUS_EN_OUT,
    output logic                   EXT_BUS_EN_OUT,
    output logic                   SWITCH_BUF_EN_OUT,
    output logic                   ONCHIP_RAM_EN_OUT,
    output logic                   SYS_RAM_SEL_OUT,
    output logic                   ROM_LOW_SEL_OUT,
    output logic                   ROM_HIGH_SEL_OUT,
    output logic                   ROM_OUT_EN_OUT,
    output logic                   EXT_VALID_STROBE_OUT,
    output logic                   EXT_READ_NOT_WRITE_OUT,
    output logic                   INT_VALID_STROBE_OUT,
    output logic                   INT_READ_NOT_WRITE_OUT,
    output logic                   ANALYSIS_TEST_POINT_OUT,
    output logic                   INTERNAL_DATA_TOP_BIT_OUT,
    output logic                   INTERNAL_DATA_TOP_BIT_OE_OUT,
    output logic [SLOTS-1:0]       SLOT_SELECT_LINE_OUT,
    output logic [DATA_W-SLOTS-1:0] LATCH_SPARE_OUT
);
    localparam int SYNC_W = ADDR_W + DATA_W + 6;

    // Decode map is fixed at a 16-bit address and an 8-bit latch
    if (ADDR_W != 16 || DATA_W != 8 || SLOTS < 1 || SLOTS >= DATA_W)
    begin
        $error("bsd_decode: unsupported width parameters");
    end

    function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
        in_span = (a >= lo) && (a <= hi);
    endfunction

    // Two-flop synchroniser for every pin except SRST_IN; first stage read only by second
    logic [SYNC_W-1:0] sync_meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic              phi2_prev_r;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (SRST_IN)
        begin
            sync_meta_r <= '0;
            sync_r      <= '0;
            phi2_prev_r <= 1'b0;
        end
        else
        begin
            sync_meta_r <= {ADDR_IN, DATA_IN, VALID_ADDR_STROBE_IN, READ_NOT_WRITE_IN,
                            PHASE_TWO_CLOCK_IN, FORCED_INSTR_IN, EXT_INHIBIT_IN,
                            ROM_DISABLE_IN};
            sync_r      <= sync_meta_r;
            phi2_prev_r <= sync_r[3];
        end
    end

    logic [15:0]       addr;
    logic [DATA_W-1:0] data;
    logic              vma;
    logic              rnw;
    logic              phi2;
    logic              forced;
    logic              inhibit;
    logic              rom_off;

    assign {addr, data, vma, rnw, phi2, forced, inhibit, rom_off} = sync_r;

    logic              int_en_r,  int_en_nxt;
    logic              ext_en_r,  ext_en_nxt;
    logic              sw_en_r,   sw_en_nxt;
    logic              onchip_r,  onchip_nxt;
    logic              ram_r,     ram_nxt;
    logic              rom_lo_r,  rom_lo_nxt;
    logic              rom_hi_r,  rom_hi_nxt;
    logic              rom_oe_r,  rom_oe_nxt;
    logic              evma_r,    evma_nxt;
    logic              erw_r,     erw_nxt;
    logic              ivma_r,    ivma_nxt;
    logic              irw_r,     irw_nxt;
    logic              tp_r,      tp_nxt;
    logic              top_oe_r,  top_oe_nxt;
    logic              latch_load;
    bsd_src_t          src;
    logic              int_blk;
    logic              ram_hit;
    logic              rom_hit;
    logic [DATA_W-1:0] latch_q;

    always_comb
    begin
        int_blk = addr[`BSD_BLK_MSB:`BSD_BLK_LSB] == `BSD_BLK_LOW   ||
                  addr[`BSD_BLK_MSB:`BSD_BLK_LSB] == `BSD_BLK_RAMIO ||
                  addr[`BSD_BLK_MSB:`BSD_BLK_LSB] == `BSD_BLK_ROM;
        ram_hit = vma && in_span(addr, `BSD_RAM_BASE, `BSD_RAM_LAST);
        rom_hit = vma && !rom_off &&
                  addr[`BSD_BLK_MSB:`BSD_BLK_LSB] == `BSD_BLK_ROM;
        // Priority order makes the sources mutually exclusive
        if (forced)
            src = BSD_SWITCH;
        else if (!vma)
            src = BSD_NONE;
        else if (addr <= `BSD_ONCHIP_LAST)
            src = BSD_ONCHIP;
        else if (addr == `BSD_LATCH_ADDR && rnw)
            src = BSD_SWITCH;
        else if (int_blk)
            src = BSD_INT;
        else
            src = BSD_EXT;

        int_en_nxt = 1'b0;
        ext_en_nxt = 1'b0;
        sw_en_nxt  = 1'b0;
        onchip_nxt = 1'b0;
        case (src)
            BSD_NONE:   ;
            BSD_INT:    int_en_nxt = 1'b1;
            BSD_EXT:    ext_en_nxt = !inhibit;
            BSD_SWITCH: sw_en_nxt  = 1'b1;
            BSD_ONCHIP: onchip_nxt = 1'b1;
            default:    ;
        endcase

        ram_nxt    = ram_hit;
        rom_lo_nxt = rom_hit && !addr[`BSD_ROM_PICK_BIT];
        rom_hi_nxt = rom_hit &&  addr[`BSD_ROM_PICK_BIT];
        rom_oe_nxt = rom_hit && rnw && phi2;

        // Strobes pass uninverted, gated to the area they address
        evma_nxt   = vma && !int_blk;
        erw_nxt    = rnw;
        ivma_nxt   = vma &&  int_blk;
        irw_nxt    = rnw;

        // Test point idles high, drops for an internal write in its window
        tp_nxt     = !(vma && !rnw && in_span(addr, `BSD_TP_BASE, `BSD_TP_LAST));

        // Pull bit 7 high where no RAM answers, so sizing reads see it set
        top_oe_nxt = !EXP_RAM_PRESENT && vma && rnw &&
                     in_span(addr, `BSD_EXP_BASE, `BSD_EXP_LAST);

        // Capture on phi2 falling: the inverted clock's rising edge
        latch_load = phi2_prev_r && !phi2 && vma && !rnw &&
                     addr == `BSD_LATCH_ADDR && !forced;
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (SRST_IN)
        begin
            int_en_r <= 1'b0;
            ext_en_r <= 1'b0;
            sw_en_r  <= 1'b0;
            onchip_r <= 1'b0;
            ram_r    <= 1'b0;
            rom_lo_r <= 1'b0;
            rom_hi_r <= 1'b0;
            rom_oe_r <= 1'b0;
            evma_r   <= 1'b0;
            erw_r    <= 1'b1;
            ivma_r   <= 1'b0;
            irw_r    <= 1'b1;
            tp_r     <= 1'b1;
            top_oe_r <= 1'b0;
        end
        else
        begin
            int_en_r <= int_en_nxt;
            ext_en_r <= ext_en_nxt;
            sw_en_r  <= sw_en_nxt;
            onchip_r <= onchip_nxt;
            ram_r    <= ram_nxt;
            rom_lo_r <= rom_lo_nxt;
            rom_hi_r <= rom_hi_nxt;
            rom_oe_r <= rom_oe_nxt;
            evma_r   <= evma_nxt;
            erw_r    <= erw_nxt;
            ivma_r   <= ivma_nxt;
            irw_r    <= irw_nxt;
            tp_r     <= tp_nxt;
            top_oe_r <= top_oe_nxt;
        end
    end

    bsd_slot_latch #(
        .DATA_W (DATA_W)
    ) u_slot_latch (
        .clk_in  (REF_CLK_IN),
        .srst_in (SRST_IN),
        .load_in (latch_load),
        .data_in (data),
        .q_out   (latch_q)
    );

    assign INT_BUS_EN_OUT               = int_en_r;
    assign EXT_BUS_EN_OUT               = ext_en_r;
    assign SWITCH_BUF_EN_OUT            = sw_en_r;
    assign ONCHIP_RAM_EN_OUT            = onchip_r;
    assign SYS_RAM_SEL_OUT              = ram_r;
    assign ROM_LOW_SEL_OUT              = rom_lo_r;
    assign ROM_HIGH_SEL_OUT             = rom_hi_r;
    assign ROM_OUT_EN_OUT               = rom_oe_r;
    assign EXT_VALID_STROBE_OUT         = evma_r;
    assign EXT_READ_NOT_WRITE_OUT       = erw_r;
    assign INT_VALID_STROBE_OUT         = ivma_r;
    assign INT_READ_NOT_WRITE_OUT       = irw_r;
    assign ANALYSIS_TEST_POINT_OUT      = tp_r;
    assign INTERNAL_DATA_TOP_BIT_OUT    = 1'b1;
    assign INTERNAL_DATA_TOP_BIT_OE_OUT = top_oe_r;
    assign SLOT_SELECT_LINE_OUT         = latch_q[SLOTS-1:0];
    assign LATCH_SPARE_OUT              = latch_q[DATA_W-1:SLOTS];

    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SRST_IN);

    chk_one_source: assert property (
        $onehot0({int_en_r, ext_en_r, sw_en_r, onchip_r}))
        else $error("more than one data source enabled");
    chk_onchip_off: assert property (
        (vma && !forced && addr <= `BSD_ONCHIP_LAST) |=> onchip_r && !int_en_r && !ext_en_r)
        else $error("buses not off during on-chip RAM access");
    chk_forced_mode: assert property (
        forced |=> sw_en_r && !int_en_r && !ext_en_r && !onchip_r)
        else $error("forced mode did not select switch source");
    chk_inhibit_ext: assert property (
        inhibit |=> !ext_en_r)
        else $error("external bus on despite inhibit");
    chk_switch_read: assert property (
        (vma && !forced && rnw && addr == `BSD_LATCH_ADDR) |=> sw_en_r && !int_en_r && !ext_en_r)
        else $error("latch address read did not select switch");
    chk_ext_outside: assert property (
        (vma && !forced && !inhibit && !int_blk) |=> ext_en_r && !int_en_r)
        else $error("external bus not on outside internal blocks");
    chk_ram_select: assert property (
        ram_r |-> $past(vma) && $past(addr) >= `BSD_RAM_BASE && $past(addr) <= `BSD_RAM_LAST)
        else $error("system RAM selected outside its range");
    chk_rom_pick: assert property (
        rom_lo_r |-> !$past(addr[`BSD_ROM_PICK_BIT]) && !rom_hi_r)
        else $error("wrong ROM device selected");
    chk_rom_clock: assert property (
        rom_oe_r |-> $past(phi2) && (rom_lo_r || rom_hi_r))
        else $error("ROM output enabled without high clock");
    chk_rom_disable: assert property (
        rom_off |=> !rom_lo_r && !rom_hi_r && !rom_oe_r)
        else $error("ROM selected while disabled");
    chk_tp_pulse: assert property (
        !tp_r |-> $past(vma) && !$past(rnw))
        else $error("test point dropped outside a write");
endmodule

// file: bsd_cpu_model.sv
// Purpose: Processor side of the decoder: address, data and strobe pins
// Assumes: Pins move only on falling edges of the system clock
// Notes:   Phase two stays high four clocks and low nine or more, above the three-clock minimum
`timescale 1ns/1ns
module bsd_cpu_model
(
    input  wire logic        clk_in,
    output logic      [15:0] addr_out,
    output logic      [7:0]  data_out,
    output logic             vma_out,
    output logic             rnw_out,
    output logic             phi2_out
);
    initial
    begin
        addr_out = 16'hffff;
        data_out = 8'hff;
        vma_out  = 1'b0;
        rnw_out  = 1'b1;
        phi2_out = 1'b0;
    end

    task automatic present(input logic [15:0] a, input logic [7:0] d, input logic rnw);
        @(negedge clk_in);
        addr_out = a;
        data_out = d;
        rnw_out  = rnw;
        vma_out  = 1'b1;
        phi2_out = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask

    task automatic fall();
        phi2_out = 1'b0;
        repeat (4) @(negedge clk_in);
    endtask

    // Released address and data lines show the inverse, so stale values cannot pass as held
    task automatic release_bus();
        vma_out  = 1'b0;
        rnw_out  = 1'b1;
        addr_out = ~addr_out;
        data_out = ~data_out;
        repeat (4) @(negedge clk_in);
    endtask
endmodule

// file: bus_select_and_memory_decode_tb.sv
// Purpose: Self-checking bench for bus select and memory decode
// Assumes: Default parameters, no expansion RAM fitted
// Notes:   Expected decode is rebuilt from the address map, not the design
`timescale 1ns/1ns
`include "bsd_params.svh"
module bus_select_and_memory_decode_tb
    import bsd_pkg::*;
();
    logic        ref_clk, srst, forced, inhib, romdis;
    logic [15:0] addr;
    logic [7:0]  data, shadow;
    logic        vma, rnw, phi2;
    logic        int_en, ext_en, sw_en, oc_en, ram_sel, rom_lo, rom_hi, rom_oe;
    logic        ext_vs, ext_rnw, int_vs, int_rnw, tp, top_bit, top_oe;
    logic [5:0]  slot;
    logic [1:0]  spare;
    int          bad_count, n_compared, cycles;

    bsd_cpu_model cpu (.clk_in(ref_clk), .addr_out(addr), .data_out(data),
                       .vma_out(vma), .rnw_out(rnw), .phi2_out(phi2));

    bsd_decode DUT (
        .REF_CLK_IN                  (ref_clk),
        .SRST_IN                     (srst),
        .ADDR_IN                     (addr),
        .DATA_IN                     (data),
        .VALID_ADDR_STROBE_IN        (vma),
        .READ_NOT_WRITE_IN           (rnw),
        .PHASE_TWO_CLOCK_IN          (phi2),
        .FORCED_INSTR_IN             (forced),
        .EXT_INHIBIT_IN              (inhib),
        .ROM_DISABLE_IN              (romdis),
        .INT_BUS_EN_OUT              (int_en),
        .EXT_BUS_EN_OUT              (ext_en),
        .SWITCH_BUF_EN_OUT           (sw_en),
        .ONCHIP_RAM_EN_OUT           (oc_en),
        .SYS_RAM_SEL_OUT             (ram_sel),
        .ROM_LOW_SEL_OUT             (rom_lo),
        .ROM_HIGH_SEL_OUT            (rom_hi),
        .ROM_OUT_EN_OUT              (rom_oe),
        .EXT_VALID_STROBE_OUT        (ext_vs),
        .EXT_READ_NOT_WRITE_OUT      (ext_rnw),
        .INT_VALID_STROBE_OUT        (int_vs),
        .INT_READ_NOT_WRITE_OUT      (int_rnw),
        .ANALYSIS_TEST_POINT_OUT     (tp),
        .INTERNAL_DATA_TOP_BIT_OUT   (top_bit),
        .INTERNAL_DATA_TOP_BIT_OE_OUT(top_oe),
        .SLOT_SELECT_LINE_OUT        (slot),
        .LATCH_SPARE_OUT             (spare)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Whole processor cycle with decode checked while phase two is high
    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic r);
        logic onc, sw, blk, rom;
        onc = a <= `BSD_ONCHIP_LAST;
        sw  = r && a == `BSD_LATCH_ADDR;
        blk = a[15:13] inside {`BSD_BLK_LOW, `BSD_BLK_RAMIO, `BSD_BLK_ROM};
        rom = a[15:13] == `BSD_BLK_ROM && !romdis;
        cpu.present(a, d, r);
        cmp_bit(sw_en, forced || (!onc && sw));
        cmp_bit(int_en, !forced && !onc && !sw && blk);
        cmp_bit(ext_en, !forced && !inhib && !blk);
        cmp_bit(oc_en, !forced && onc);
        cmp_bit(int_rnw, r);
        cmp_bit(ext_rnw, r);
        cmp_bit(tp, r || a[15:11] != 5'h07);
        if (!forced)
        begin
            cmp_bit(ram_sel, a >= `BSD_RAM_BASE && a <= `BSD_RAM_LAST);
            cmp_bit(rom_lo, rom && !a[12]);
            cmp_bit(rom_hi, rom && a[12]);
            cmp_bit(rom_oe, rom && r);
            cmp_bit(top_oe, r && a[15:11] == 5'h05);
        end
        if (!forced && !inhib && !onc)
        begin
            cmp_bit(int_vs, blk);
            cmp_bit(ext_vs, !blk);
        end
        cpu.fall();
        cmp_bit(rom_oe, 1'b0);
        cpu.release_bus();
    endtask

    task automatic t_reset();
        srst = 1'b1;
        repeat (2) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        cmp_bit(int_en | ext_en | sw_en, 1'b0);
        cmp_bit(tp, 1'b1);
        cmp_byte({spare, slot}, `BSD_LATCH_RESET);
        shadow = `BSD_LATCH_RESET;
    endtask

    task automatic t_map();
        logic [15:0] am [14] = '{16'h0010, 16'h0090, 16'h1fff, 16'h2000, 16'h27ff,
                                 16'h2c00, 16'h3000, 16'h3800, 16'h4000, 16'hdfff,
                                 16'he000, 16'hefff, 16'hf000, 16'hffff};
        for (int r = 0; r < 2; r++)
            foreach (am[i])
                access(am[i], shadow, r[0]);
        cmp_bit(top_bit, 1'b1);
    endtask

    task automatic t_latch();
        logic [7:0] d;
        for (int k = 0; k < 6; k++)
        begin
            d = 8'h80 | (8'h01 << k);
            access(`BSD_LATCH_ADDR, d, 1'b0);
            shadow = d;
            cmp_byte({spare, slot}, d);
        end
        access(16'h3001, 8'h3f, 1'b0);
        access(`BSD_LATCH_ADDR, 8'h3f, 1'b1);
        cmp_byte({spare, slot}, shadow);
    endtask

    task automatic t_modes();
        @(negedge ref_clk);
        inhib = 1'b1;
        access(16'h4000, 8'h00, 1'b1);
        access(16'h2000, 8'h00, 1'b0);
        inhib  = 1'b0;
        romdis = 1'b1;
        access(16'he000, 8'h00, 1'b1);
        access(16'hf000, 8'h00, 1'b1);
        romdis = 1'b0;
        forced = 1'b1;
        access(16'h0010, 8'h00, 1'b1);
        access(16'h4000, 8'h00, 1'b1);
        access(`BSD_LATCH_ADDR, 8'h02, 1'b0);
        forced = 1'b0;
        cmp_byte({spare, slot}, shadow);
    endtask

    // Run needs about 570 clocks; the ceiling leaves wide margin
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        srst       = 1'b1;
        forced     = 1'b0;
        inhib      = 1'b0;
        romdis     = 1'b0;
        bad_count  = 0;
        n_compared = 0;
        cycles     = 0;
        t_reset();
        repeat (3) @(negedge ref_clk);
        t_map();
        t_latch();
        t_modes();
        tally_and_finish();
    end
endmodule
